// [verilog/mpf_cfg.svh]
`ifndef MPF_CFG_SVH
`define MPF_CFG_SVH

// Clock and pulse time base
`define MPF_CLK_HZ 125000000
`define MPF_TICK_HZ 40000000
`define MPF_TICK_RES_HZ 1000000

// Sizes
`define MPF_NCH 4
`define MPF_NPULSE 5
`define MPF_POS_W 16
`define MPF_LEN_W 18
`define MPF_GAP_W 24
`define MPF_REGS_PER_CH 12
`define MPF_MEM_WORDS 48

// Avalon word offsets inside one channel window (byte address = 4 * index)
`define MPF_OFS_CTRL 4'h0
`define MPF_OFS_START 4'h1
`define MPF_OFS_LEAD1 4'h2
`define MPF_OFS_LEAD2 4'h3
`define MPF_OFS_LEN1 4'h4
`define MPF_OFS_LEN2 4'h5
`define MPF_OFS_LENP 4'h6
`define MPF_OFS_GAP3 4'h7
`define MPF_OFS_LEN3 4'h8
`define MPF_OFS_GAP4 4'h9
`define MPF_OFS_LEN4 4'ha
`define MPF_OFS_HAND 4'hb
// Channel windows at 0x000, 0x040, 0x080, 0x0c0; status word above them
`define MPF_ADDR_STATUS 9'h100

// Control word bit positions
`define MPF_BIT_MASTER 0
`define MPF_BIT_EARLY1 1
`define MPF_BIT_EARLY2 2
`define MPF_BIT_LATE1 3
`define MPF_BIT_LATE2 4
`define MPF_CTRL_W 5

// Status word fields
`define MPF_ST_CH_LSB 0
`define MPF_ST_KEY_BIT 2
`define MPF_ST_OUT_LSB 4

// Reset value of every configuration word (all pulses disabled)
`define MPF_CFG_RST 32'h0000_0000

// Unlock key; value is arbitrary
`define MPF_KEY_DEFAULT 32'h5a3c_96e1

`endif

// [verilog/mpf_pkg.sv]
`include "mpf_cfg.svh"

package mpf_pkg;

  // Position bundle from the engine position tracker
  typedef struct packed {
    logic synced;
    logic [`MPF_POS_W-1:0] crank_angle_tick;
  } mpf_timing_s;

  // One channel's pulse settings as sampled at activation
  typedef struct packed {
    logic master_pulse_gate;
    logic first_early_pulse_on;
    logic second_early_pulse_on;
    logic first_late_pulse_on;
    logic second_late_pulse_on;
    logic [`MPF_POS_W-1:0] primary_start_angle;
    logic [`MPF_POS_W-1:0] first_early_lead_ticks;
    logic [`MPF_POS_W-1:0] second_early_lead_ticks;
    logic [`MPF_LEN_W-1:0] first_early_length;
    logic [`MPF_LEN_W-1:0] second_early_length;
    logic [`MPF_LEN_W-1:0] primary_length;
    logic [`MPF_GAP_W-1:0] first_late_gap;
    logic [`MPF_LEN_W-1:0] first_late_length;
    logic [`MPF_GAP_W-1:0] second_late_gap;
    logic [`MPF_LEN_W-1:0] second_late_length;
    logic [`MPF_POS_W-1:0] channel_handover_angle;
  } mpf_chan_cfg_s;

  // Late pulse delay phase
  typedef enum logic {
    MPF_LATE_IDLE = 1'b0,
    MPF_LATE_WAIT = 1'b1
  } mpf_late_e;

endpackage

// [verilog/mpf_pulse_unit.sv]
`timescale 1ns/1ps
`include "mpf_cfg.svh"

module mpf_pulse_unit (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick,
  input wire logic pos_new,
  input wire logic [`MPF_POS_W-1:0] pos,
  input wire mpf_pkg::mpf_chan_cfg_s cfg,
  output logic [`MPF_NPULSE-1:0] win
);
  import mpf_pkg::*;

  // Pulse order: 0 first early, 1 second early, 2 primary, 3 first late, 4 second late
  logic [`MPF_NPULSE-1:0][`MPF_LEN_W-1:0] len_w;
  logic [`MPF_NPULSE-1:0][`MPF_LEN_W-1:0] cnt;
  logic [`MPF_NPULSE-1:0] en_w;
  logic [`MPF_NPULSE-1:0] start_w;
  logic [`MPF_NPULSE-1:0] end_w;
  logic [1:0][`MPF_GAP_W-1:0] gap_cfg;
  logic [1:0][`MPF_GAP_W-1:0] gap_cnt;
  logic [1:0] late_trig;
  logic [1:0] late_go;
  mpf_late_e late_st [2];
  logic [`MPF_POS_W-1:0] pos_early1;
  logic [`MPF_POS_W-1:0] pos_early2;

  // Enables: every pulse behind the master gate, second late also behind first late
  assign en_w[0] = cfg.master_pulse_gate & cfg.first_early_pulse_on;
  assign en_w[1] = cfg.master_pulse_gate & cfg.second_early_pulse_on;
  assign en_w[2] = cfg.master_pulse_gate;
  assign en_w[3] = cfg.master_pulse_gate & cfg.first_late_pulse_on;
  assign en_w[4] = en_w[3] & cfg.second_late_pulse_on;

  assign len_w[0] = cfg.first_early_length;
  assign len_w[1] = cfg.second_early_length;
  assign len_w[2] = cfg.primary_length;
  assign len_w[3] = cfg.first_late_length;
  assign len_w[4] = cfg.second_late_length;
  assign gap_cfg[0] = cfg.first_late_gap;
  assign gap_cfg[1] = cfg.second_late_gap;

  // Early starts lead the primary start angle, modulo the position width
  assign pos_early1 = cfg.primary_start_angle - cfg.first_early_lead_ticks;
  assign pos_early2 = cfg.primary_start_angle - cfg.second_early_lead_ticks;

  // Position starts fire once, on the first clock of a new position
  assign start_w[0] = pos_new & (pos == pos_early1);
  assign start_w[1] = pos_new & (pos == pos_early2);
  assign start_w[2] = pos_new & (pos == cfg.primary_start_angle);
  assign start_w[3] = late_go[0];
  assign start_w[4] = late_go[1];

  // Late pulses chain on the end of the pulse before them
  assign late_trig[0] = end_w[2];
  assign late_trig[1] = end_w[3];

  genvar gi;
  generate
    for (gi = 0; gi < `MPF_NPULSE; gi++) begin : g_len
      // Window length counted down in time-base ticks; zero length gives no pulse
      always_ff @(posedge clk_sys) begin
        if (!rst_n || clear) begin
          cnt[gi] <= '0;
        end else if (start_w[gi] && en_w[gi]) begin
          cnt[gi] <= len_w[gi];
        end else if (tick && cnt[gi] != '0) begin
          cnt[gi] <= cnt[gi] - `MPF_LEN_W'(1);
        end
      end
      assign end_w[gi] = tick & (cnt[gi] == `MPF_LEN_W'(1)) & ~clear;
      assign win[gi] = (cnt[gi] != '0) & en_w[gi];
    end

    for (gi = 0; gi < 2; gi++) begin : g_late
      assign late_go[gi] = (late_st[gi] == MPF_LATE_WAIT) & (gap_cnt[gi] == '0) & ~clear;
      // Time delay after the previous pulse ends, not a position delay
      always_ff @(posedge clk_sys) begin
        if (!rst_n || clear) begin
          late_st[gi] <= MPF_LATE_IDLE;
          gap_cnt[gi] <= '0;
        end else begin
          unique case (late_st[gi])
            MPF_LATE_IDLE: begin
              if (late_trig[gi] && en_w[gi+3]) begin
                late_st[gi] <= MPF_LATE_WAIT;
                gap_cnt[gi] <= gap_cfg[gi];
              end
            end
            MPF_LATE_WAIT: begin
              if (gap_cnt[gi] == '0) begin
                late_st[gi] <= MPF_LATE_IDLE;
              end else if (tick) begin
                gap_cnt[gi] <= gap_cnt[gi] - `MPF_GAP_W'(1);
              end
            end
          endcase
        end
      end
    end
  endgenerate

  // Gated pulses never show a window
  a_gate_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg.master_pulse_gate |-> win == '0) else $error("pulse open with master gate off");

  a_early_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (win[0] |-> cfg.first_early_pulse_on) and (win[1] |-> cfg.second_early_pulse_on))
    else $error("early pulse without its enable");

  a_post_chained: assert property (@(posedge clk_sys) disable iff (!rst_n)
    win[4] |-> cfg.first_late_pulse_on) else $error("second late pulse without first");

  a_main_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (start_w[2] && !clear && cfg.master_pulse_gate && cfg.primary_length != '0)
    |=> (cnt[2] == $past(cfg.primary_length)) && win[2])
    else $error("primary pulse did not open at its angle");

  a_len_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cnt[2] != '0 && !tick && !clear && !start_w[2]) |=> cnt[2] == $past(cnt[2]))
    else $error("primary length moved without a tick");

  sequence s_gap_done;
    late_st[0] == MPF_LATE_WAIT && gap_cnt[0] == '0 && !clear && en_w[3];
  endsequence

  sequence s_after_open;
    cnt[3] == $past(cfg.first_late_length);
  endsequence

  a_after_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_gap_done |=> s_after_open) else $error("first late pulse late after gap");

  a_post_gap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (late_trig[1] && en_w[4] && late_st[1] == MPF_LATE_IDLE)
    |=> late_st[1] == MPF_LATE_WAIT && gap_cnt[1] == $past(cfg.second_late_gap))
    else $error("second late gap not loaded");

endmodule

// [verilog/mpf_top.sv]
`timescale 1ns/1ps
`include "mpf_cfg.svh"

// Contract
// - Up to five pulses per channel per cycle
// - Outputs stay off until key unlocks
// - Single-cycle iteration; durations in 40 MHz ticks
// - Master gate, default off, blocks all pulses
// - Early and late pulses need own enable
// - Second late pulse needs first late enabled
// - Primary opens at start angle, lasts length
// - Early pulses lead start angle by ticks
// - Lengths are 18-bit tick counts, wrapping
// - First late starts gap after primary ends
// - Second late starts gap after first late
// - Shared engine moves to next channel
// - Handover strobe lasts exactly one clock
// - Four separate pulse train outputs
module mpf_top #(
  parameter logic [31:0] KEY_VALUE = `MPF_KEY_DEFAULT,
  parameter int NCH = `MPF_NCH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire mpf_pkg::mpf_timing_s engine_timing_bundle,
  input wire logic [31:0] unlock_key,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic handover_strobe,
  output logic pulse_train_out_1,
  output logic pulse_train_out_2,
  output logic pulse_train_out_3,
  output logic pulse_train_out_4
);
  import mpf_pkg::*;

  localparam int ACC_MOD = `MPF_CLK_HZ / `MPF_TICK_RES_HZ;
  localparam int ACC_STEP = `MPF_TICK_HZ / `MPF_TICK_RES_HZ;

  // Field width mask per word; narrow fields read back with zeros above
  function automatic logic [31:0] field_mask(input logic [3:0] w);
    logic [31:0] m;
    m = '0;
    unique case (w)
      `MPF_OFS_CTRL: m = 32'((1 << `MPF_CTRL_W) - 1);
      `MPF_OFS_START, `MPF_OFS_LEAD1, `MPF_OFS_LEAD2, `MPF_OFS_HAND:
        m = 32'((1 << `MPF_POS_W) - 1);
      `MPF_OFS_GAP3, `MPF_OFS_GAP4: m = 32'((1 << `MPF_GAP_W) - 1);
      default: m = 32'((1 << `MPF_LEN_W) - 1);
    endcase
    return m;
  endfunction

  // Word index of a channel's field in the settings memory
  function automatic logic [5:0] mem_index(input logic [1:0] ch, input logic [3:0] w);
    return 6'(ch) * 6'(`MPF_REGS_PER_CH) + 6'(w);
  endfunction

  logic [31:0] cfg_mem [`MPF_MEM_WORDS];
  logic [6:0] acc;
  logic [7:0] acc_sum;
  logic [6:0] next_acc;
  logic tick;
  logic [`MPF_POS_W-1:0] pos_prev;
  logic pos_valid_prev;
  logic pos_new;
  logic [1:0] active_ch;
  logic [1:0] next_ch;
  logic handover;
  mpf_chan_cfg_s cfg_q;
  mpf_chan_cfg_s cfg_next;
  logic [`MPF_NPULSE-1:0] win;
  logic any_win;
  logic key_ok;
  logic bus_req;
  logic bus_go;
  logic [1:0] a_ch;
  logic [3:0] a_w;
  logic hit_cfg;
  logic hit_status;
  logic [5:0] a_idx;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [3:0] out_vec;
  logic [5:0] nb;

  // Fractional divider: 40 MHz time-base enable from the 125 MHz clock
  assign acc_sum = 8'(acc) + 8'(ACC_STEP);
  assign tick = acc_sum >= 8'(ACC_MOD);
  assign next_acc = tick ? 7'(acc_sum - 8'(ACC_MOD)) : 7'(acc_sum);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  // New position seen once per tracker step; the bundle needs no sync, same clock
  assign pos_new = engine_timing_bundle.synced &&
                   (!pos_valid_prev || engine_timing_bundle.crank_angle_tick != pos_prev);
  assign handover = pos_new &&
                    engine_timing_bundle.crank_angle_tick == cfg_q.channel_handover_angle;
  assign next_ch = active_ch + 2'h1;

  // Unlock: key is already registered by the integrator, so compare directly
  assign key_ok = unlock_key == KEY_VALUE;

  // Settings of the next channel, cut to field widths (wraps modulo width)
  assign nb = mem_index(next_ch, 4'h0);
  assign cfg_next.master_pulse_gate = cfg_mem[nb][`MPF_BIT_MASTER];
  assign cfg_next.first_early_pulse_on = cfg_mem[nb][`MPF_BIT_EARLY1];
  assign cfg_next.second_early_pulse_on = cfg_mem[nb][`MPF_BIT_EARLY2];
  assign cfg_next.first_late_pulse_on = cfg_mem[nb][`MPF_BIT_LATE1];
  assign cfg_next.second_late_pulse_on = cfg_mem[nb][`MPF_BIT_LATE2];
  assign cfg_next.primary_start_angle = cfg_mem[nb + 6'(`MPF_OFS_START)][`MPF_POS_W-1:0];
  assign cfg_next.first_early_lead_ticks = cfg_mem[nb + 6'(`MPF_OFS_LEAD1)][`MPF_POS_W-1:0];
  assign cfg_next.second_early_lead_ticks = cfg_mem[nb + 6'(`MPF_OFS_LEAD2)][`MPF_POS_W-1:0];
  assign cfg_next.first_early_length = cfg_mem[nb + 6'(`MPF_OFS_LEN1)][`MPF_LEN_W-1:0];
  assign cfg_next.second_early_length = cfg_mem[nb + 6'(`MPF_OFS_LEN2)][`MPF_LEN_W-1:0];
  assign cfg_next.primary_length = cfg_mem[nb + 6'(`MPF_OFS_LENP)][`MPF_LEN_W-1:0];
  assign cfg_next.first_late_gap = cfg_mem[nb + 6'(`MPF_OFS_GAP3)][`MPF_GAP_W-1:0];
  assign cfg_next.first_late_length = cfg_mem[nb + 6'(`MPF_OFS_LEN3)][`MPF_LEN_W-1:0];
  assign cfg_next.second_late_gap = cfg_mem[nb + 6'(`MPF_OFS_GAP4)][`MPF_GAP_W-1:0];
  assign cfg_next.second_late_length = cfg_mem[nb + 6'(`MPF_OFS_LEN4)][`MPF_LEN_W-1:0];
  assign cfg_next.channel_handover_angle = cfg_mem[nb + 6'(`MPF_OFS_HAND)][`MPF_POS_W-1:0];

  // Handover moves the shared engine on and samples that channel's group whole;
  // writes during a channel's turn wait until its next turn
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pos_prev <= '0;
      pos_valid_prev <= 1'b0;
      active_ch <= '0;
      cfg_q <= '0;
      handover_strobe <= 1'b0;
    end else begin
      pos_prev <= engine_timing_bundle.crank_angle_tick;
      pos_valid_prev <= engine_timing_bundle.synced;
      handover_strobe <= handover;
      if (handover) begin
        active_ch <= next_ch;
        cfg_q <= cfg_next;
      end
    end
  end

  // One shared engine; cleared on handover so no window spills into the next channel
  mpf_pulse_unit u_engine (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(handover),
    .tick(tick),
    .pos_new(pos_new),
    .pos(engine_timing_bundle.crank_angle_tick),
    .cfg(cfg_q),
    .win(win)
  );

  assign any_win = |win;

  genvar gc;
  generate
    for (gc = 0; gc < 4; gc++) begin : g_out
      assign out_vec[gc] = key_ok && any_win && active_ch == 2'(gc);
    end
  endgenerate

  // Registered pulse trains, one port per channel
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pulse_train_out_1 <= 1'b0;
      pulse_train_out_2 <= 1'b0;
      pulse_train_out_3 <= 1'b0;
      pulse_train_out_4 <= 1'b0;
    end else begin
      pulse_train_out_1 <= out_vec[0];
      pulse_train_out_2 <= out_vec[1];
      pulse_train_out_3 <= out_vec[2];
      pulse_train_out_4 <= out_vec[3];
    end
  end

  // Avalon decode: channel windows of 16 words, twelve used
  assign bus_req = avs_read ^ avs_write;
  assign bus_go = bus_req && !avs_waitrequest;
  assign a_ch = avs_address[7:6];
  assign a_w = avs_address[5:2];
  assign hit_cfg = !avs_address[8] && a_w < 4'(`MPF_REGS_PER_CH);
  assign hit_status = avs_address[8:2] == 7'(`MPF_ADDR_STATUS >> 2);
  assign a_idx = mem_index(a_ch, a_w);
  assign status_word = {24'h0, out_vec, 1'b0, key_ok, active_ch};
  assign rd_word = hit_cfg ? (cfg_mem[a_idx] & field_mask(a_w)) :
                   hit_status ? status_word : 32'h0000_0000;

  // Fixed one wait state: capture in the wait cycle, complete on the next edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (bus_req && avs_waitrequest) begin
        avs_readdata <= avs_read ? rd_word : 32'h0000_0000;
      end
    end
  end

  // Settings memory; byte lanes honoured, write lands on the completing edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < `MPF_MEM_WORDS; i++) begin
        cfg_mem[i] <= `MPF_CFG_RST;
      end
    end else if (bus_go && avs_write && hit_cfg) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          cfg_mem[a_idx][b*8 +: 8] <= avs_writedata[b*8 +: 8];
        end
      end
    end
  end

  a_tick_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick |=> !tick [*2]) else $error("time base faster than 40 MHz");

  a_locked_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !key_ok |=> !(pulse_train_out_1 | pulse_train_out_2 | pulse_train_out_3 |
    pulse_train_out_4)) else $error("output active while locked");

  a_strobe_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
    handover_strobe |=> !handover_strobe) else $error("handover strobe too long");

  a_handover_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    handover |=> handover_strobe && active_ch == 2'($past(active_ch) + 2'h1))
    else $error("engine did not move to next channel");

  a_or_output: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (key_ok && any_win && active_ch == 2'h2) |=> pulse_train_out_3 && !pulse_train_out_1)
    else $error("channel output does not follow windows");

  a_wait_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low twice");

endmodule

// [dv/mpf_far_model.sv]
`timescale 1ns/1ps
`include "mpf_cfg.svh"

// Stand-in for the position tracker and the output supervisor
module mpf_far_model #(
  parameter int STEP = 16,
  parameter int CYC = 200
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [31:0] key_src,
  output mpf_pkg::mpf_timing_s engine_timing_bundle,
  output logic [31:0] unlock_key
);
  import mpf_pkg::*;
  int div;

  // Position steps every STEP clocks and wraps at CYC; held while not running
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div <= 0;
      engine_timing_bundle <= '0;
    end else if (run) begin
      engine_timing_bundle.synced <= 1'b1;
      div <= (div == STEP - 1) ? 0 : div + 1;
      if (div == STEP - 1) begin
        if (engine_timing_bundle.crank_angle_tick == 16'(CYC - 1)) begin
          engine_timing_bundle.crank_angle_tick <= '0;
        end else begin
          engine_timing_bundle.crank_angle_tick <= engine_timing_bundle.crank_angle_tick + 16'h1;
        end
      end
    end
  end

  // Exactly one register between supervisor key and generator
  always_ff @(posedge clk_sys) begin
    unlock_key <= key_src;
  end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
`include "mpf_cfg.svh"

module tb_top;
  import mpf_pkg::*;
  localparam logic [31:0] KEY = 32'h1234_abcd; // Arbitrary unlock value
  logic clk_sys, rst_n, run, avs_read, avs_write, avs_waitrequest, handover_strobe;
  logic strobe_q = 1'b0;
  logic [8:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, key_src, unlock_key, rd;
  logic [3:0] avs_byteenable, outs;
  logic [3:0] outs_q = 4'h0;
  mpf_timing_s engine_timing_bundle;
  int failures, checks, act, dbl, others, key_good, cyc_n, k, ch, nh;
  int rise_t[$], fall_t[$], rise_p[$];
  int hand[4] = '{20, 80, 130, 180};
  int wid[12] = '{5, 16, 16, 16, 18, 18, 18, 24, 18, 24, 18, 16};
  int cfg1[12] = '{31, 30, 4, 2, 4, 5, 6, 6, 5, 7, 4, 80};
  int len[5] = '{4, 5, 6, 5, 4};
  int lead[5] = '{4, 2, 0, 0, 0};
  int gap[5] = '{0, 0, 0, 6, 7};
  logic [4:0] combo[7] = '{5'h1f, 5'h1f, 5'h1e, 5'h11, 5'h19, 5'h03, 5'h07};

  mpf_top #(.KEY_VALUE(KEY), .NCH(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .engine_timing_bundle(engine_timing_bundle), .unlock_key(unlock_key),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .handover_strobe(handover_strobe), .pulse_train_out_1(outs[0]),
    .pulse_train_out_2(outs[1]), .pulse_train_out_3(outs[2]), .pulse_train_out_4(outs[3]));

  mpf_far_model #(.STEP(16), .CYC(200)) far (.clk_sys(clk_sys), .rst_n(rst_n), .run(run),
    .key_src(key_src), .engine_timing_bundle(engine_timing_bundle), .unlock_key(unlock_key));

  // Clock at 125 MHz
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Edge recorder for channel 1, stray edges and stretched strobes
  always @(posedge clk_sys) begin
    cyc_n <= cyc_n + 1;
    outs_q <= outs;
    strobe_q <= handover_strobe;
    if (outs[1] === 1'b1 && outs_q[1] === 1'b0) begin
      rise_t.push_back(cyc_n);
      rise_p.push_back(engine_timing_bundle.crank_angle_tick);
    end
    if (outs[1] === 1'b0 && outs_q[1] === 1'b1) fall_t.push_back(cyc_n);
    if ((outs & ~outs_q & 4'hd) !== 4'h0) others++;
    if (handover_strobe === 1'b1 && strobe_q === 1'b1) dbl++;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Tick spacing jitters between 3 and 4 clocks, so allow a small margin
  function automatic int near(input int seen, input int exp);
    return (seen - exp <= 5 && exp - seen <= 5) ? exp : seen;
  endfunction

  // One Avalon transfer; waits for waitrequest low under a bound
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) failures++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Wait for one handover and follow it in the model
  task automatic handover();
    int n;
    n = 0;
    while (handover_strobe !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 4000) failures++;
    // Channel 0 starts with an all-zero snapshot, so its first turn ends at angle 0
    check("handover angle", engine_timing_bundle.crank_angle_tick,
          (nh == 0) ? 0 : hand[act]);
    nh++;
    act = (act + 1) % 4;
    bus(1'b0, 9'h100, 32'h0);
    check("status", rd[2:0], {key_good[0], act[1:0]});
  endtask

  // One turn of channel 1; the next setting is written while it runs
  task automatic turn(input int i);
    int np;
    logic [4:0] c, en;
    c = combo[i];
    while (act != 1) handover();
    rise_t.delete();
    fall_t.delete();
    rise_p.delete();
    key_src <= (i == 0) ? ~KEY : KEY;
    key_good = (i != 0);
    if (i < 6) bus(1'b1, 9'h040, {27'h0, combo[i + 1]});
    handover();
    en = {c[4] & c[3], c[3], 1'b1, c[2], c[1]} & {5{c[0] && i != 0}};
    check("pulse count", rise_t.size(), $countones(en));
    np = 0;
    if (rise_t.size() == $countones(en) && fall_t.size() == rise_t.size()) begin
      for (int p = 0; p < 5; p++) begin
        if (en[p]) begin
          check("width", near(fall_t[np] - rise_t[np], len[p] * 125 / 40),
                len[p] * 125 / 40);
          if (p < 3) check("start", rise_p[np], 30 - lead[p]);
          else check("gap", near(rise_t[np] - fall_t[np - 1], gap[p] * 125 / 40),
                     gap[p] * 125 / 40);
          np++;
        end
      end
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog at 8 * 40000 ns, about twelve engine cycles of 25600 ns; the seven turns need about seven
  initial begin
    #(8 * 40000);
    failures++;
    finish_test();
  end

  // Main sequence
  initial begin
    void'($urandom(35319));
    rst_n = 1'b0;
    run = 1'b0;
    avs_address = 9'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    key_src = 32'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    check("idle bus", avs_waitrequest, 1'b1);
    check("idle outputs", {handover_strobe, outs}, 5'h0);
    bus(1'b0, 9'h0c0, 32'h0);
    check("ctrl default", rd, 32'h0);
    for (k = 0; k < 12; k++) begin
      logic [31:0] d;
      d = $urandom;
      bus(1'b1, 9'h0c0 + 9'(k * 4), d);
      bus(1'b0, 9'h0c0 + 9'(k * 4), 32'h0);
      check("field", rd, d & ((32'h1 << wid[k]) - 32'h1));
    end
    bus(1'b1, 9'h030, 32'hffff_ffff);
    bus(1'b0, 9'h030, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test registers done");
    for (ch = 0; ch < 4; ch++) begin
      for (k = 0; k < 12; k++) begin
        bus(1'b1, 9'(ch * 64 + k * 4), (k == 11) ? hand[ch] : ((ch == 1) ? cfg1[k] : 0));
      end
    end
    run <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      turn(i);
      $display("test turn %0d done", i);
    end
    check("other outputs", others, 0);
    check("long strobe", dbl, 0);
    finish_test();
  end
endmodule
